// ### crb_core_regs.sv
// Behaviour
// RULE1: Indirect ports access memory addressed by their pointer pair.
// RULE2: Flag-affecting ops into status keep computed zero, nibble, carry.
// RULE3: Watchdog and sleep flags ignore every instruction write.
// RULE4: Watchdog flag set on power-up, clear, sleep; cleared on timeout.
// RULE5: Sleep flag set on power-up or clear; cleared by sleep.
// RULE6: Zero flag follows whether result is zero.
// RULE7: Nibble flag is carry out of bit three for add, subtract.
// RULE8: Carry flag is carry out of bit seven for add, subtract.
// RULE9: Subtract adds two's complement; carries mean no borrow.
// RULE10: Rotates load carry with bit shifted out.
// RULE11: Status bits seven to five read zero.
// RULE12: Power reset gives status 0x18; other resets keep arithmetic flags.
// RULE13: Zeroing status clears upper bits, sets zero, keeps protected.
// RULE14: Twenty special registers follow core, except banks 27 to 29.
// RULE15: Eighty RAM bytes per bank, also reachable via pointers.
// RULE16: Sixteen common bytes shared by every bank.
// RULE17: Program counter high latch holds seven bits only.
// RULE18: Program counter low resets to zero on every reset; here only i_resetn clears it, power reset leaves it.
// RULE19: Twelve-bit address: five bank bits, seven offset bits.
// RULE20: Unimplemented locations read zero.
// RULE21: Each pointer pair forms a sixteen-bit address; accesses here use only high bits 4..0 and low bits 6..0.
// RULE22: Core registers mirrored at 0x00-0x0B and 0x80-0x8B everywhere.
// RULE23: Status writes touch only unprotected, implemented bits.
`timescale 1ns/1ps
module crb_core_regs
    import crb_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_power_resetn,
    input wire crb_exec_type i_exec,
    input wire crb_event_type i_event,
    input wire logic i_pc_load,
    input wire logic [7:0] i_pc_low,
    input wire logic i_rd,
    input wire logic [11:0] i_rd_addr,
    input wire logic i_indirect_sel,
    output logic [7:0] o_rd_data,
    output logic [7:0] o_status,
    output logic [7:0] o_pc_high_latch,
    output logic [7:0] o_working_accumulator,
    output logic [15:0] o_pointer0,
    output logic [15:0] o_pointer1
);
    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic [7:0] status, next_status;
    logic [7:0] pc_low, next_pc_low;
    logic [7:0] ptr0_low, next_ptr0_low, ptr0_high, next_ptr0_high;
    logic [7:0] ptr1_low, next_ptr1_low, ptr1_high, next_ptr1_high;
    logic [7:0] bank_select, next_bank_select;
    logic [7:0] wacc, next_wacc;
    logic [7:0] program_counter_high_latch, next_program_counter_high_latch;
    logic [7:0] intctl, next_intctl;
    logic [7:0] general_purpose_ram [BANKS*GPR_BYTES];
    logic [7:0] common [COMMON_BYTES];
    logic [7:0] rd_data, next_rd_data;
    logic [8:0] sum;
    logic [4:0] nib;
    logic [7:0] result, opb;
    logic arith, flagop, zres, rotop;
    logic [11:0] wr_addr, rd_eff;
    logic [6:0] wr_off;
    logic wr_core, wr_en;

    // ------------------------------------------------------------------
    // Arithmetic
    // ------------------------------------------------------------------
    always_comb begin
        arith = (i_exec.op == CRB_OP_ADD) || (i_exec.op == CRB_OP_SUB);
        rotop = i_exec.op inside {CRB_OP_ROT_LEFT, CRB_OP_ROT_RIGHT};
        opb = (i_exec.op == CRB_OP_SUB) ? (~i_exec.b) : i_exec.b; // RULE9
        sum = {1'b0, i_exec.a} + {1'b0, opb}
            + {8'h00, i_exec.op == CRB_OP_SUB}; // RULE9
        nib = {1'b0, i_exec.a[3:0]} + {1'b0, opb[3:0]}
            + {4'h0, i_exec.op == CRB_OP_SUB}; // RULE7
        unique case (i_exec.op)
            CRB_OP_ADD, CRB_OP_SUB: result = sum[7:0];
            CRB_OP_ROT_LEFT: result = {i_exec.a[6:0], status[ST_CARRY]};
            CRB_OP_ROT_RIGHT: result = {status[ST_CARRY], i_exec.a[7:1]};
            CRB_OP_ZEROING: result = RST_ZERO_BYTE;
            default: result = i_exec.a;
        endcase
        zres = (result == RST_ZERO_BYTE);
        flagop = i_exec.valid && (arith || i_exec.op == CRB_OP_LOGIC
            || i_exec.op == CRB_OP_ZEROING);
    end

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    always_comb begin
        wr_off = i_exec.dest_off;
        wr_core = wr_off <= OFF_CORE_LAST; // RULE22
        wr_addr = {bank_select[4:0], wr_off}; // RULE19
        if (wr_core && wr_off == OFF_INDIRECT_PORT0) begin
            wr_addr = {ptr0_high[4:0], ptr0_low[6:0]}; // RULE1 RULE21
        end else if (wr_core && wr_off == OFF_INDIRECT_PORT1) begin
            wr_addr = {ptr1_high[4:0], ptr1_low[6:0]}; // RULE1 RULE21
        end
        wr_en = i_exec.valid && i_exec.dest_write;
        rd_eff = i_rd_addr;
        if (i_indirect_sel || i_rd_addr[6:0] == OFF_INDIRECT_PORT1) begin
            rd_eff = {ptr1_high[4:0], ptr1_low[6:0]}; // RULE1
        end else if (i_rd_addr[6:0] == OFF_INDIRECT_PORT0) begin
            rd_eff = {ptr0_high[4:0], ptr0_low[6:0]}; // RULE1
        end
    end

    // ------------------------------------------------------------------
    // Core register next state
    // ------------------------------------------------------------------
    always_comb begin
        next_status = status;
        next_pc_low = i_pc_load ? i_pc_low : pc_low;
        next_ptr0_low = ptr0_low;
        next_ptr0_high = ptr0_high;
        next_ptr1_low = ptr1_low;
        next_ptr1_high = ptr1_high;
        next_bank_select = bank_select;
        next_wacc = wacc;
        next_program_counter_high_latch = program_counter_high_latch;
        next_intctl = intctl;
        if (wr_en && wr_core && wr_off != OFF_INDIRECT_PORT0
            && wr_off != OFF_INDIRECT_PORT1) begin
            unique case (wr_off)
                OFF_PROGRAM_COUNTER_LOW: next_pc_low = result;
                OFF_ALU_AND_RESET_FLAGS: begin
                    // Flag-affecting ops lose their write to bits 2..0
                    if (!flagop && !rotop) begin
                        next_status[2:0] = result[2:0]; // RULE2 RULE23
                    end
                end
                OFF_POINTER0_LOW: next_ptr0_low = result;
                OFF_POINTER0_HIGH: next_ptr0_high = result;
                OFF_POINTER1_LOW: next_ptr1_low = result;
                OFF_POINTER1_HIGH: next_ptr1_high = result;
                OFF_BANK_SELECT:
                    next_bank_select = result & MASK_BANK_SELECT;
                OFF_WORKING_ACCUMULATOR: next_wacc = result;
                OFF_PC_HIGH_LATCH:
                    next_program_counter_high_latch = result & MASK_PC_HIGH_LATCH; // RULE17
                OFF_INTERRUPT_GLOBAL_CONTROL:
                    next_intctl = result & MASK_INTERRUPT_GLOBAL_CONTROL;
                default: next_wacc = wacc;
            endcase
        end
        if (flagop) begin
            next_status[ST_ZERO] = zres; // RULE2 RULE6 RULE13
        end
        if (i_exec.valid && arith) begin
            next_status[ST_NIBBLE] = nib[NIBBLE_BIT]; // RULE2 RULE7 RULE9
            next_status[ST_CARRY] = sum[8]; // RULE2 RULE8 RULE9
        end
        if (i_exec.valid && i_exec.op == CRB_OP_ROT_LEFT) begin
            next_status[ST_CARRY] = i_exec.a[7]; // RULE10
        end
        if (i_exec.valid && i_exec.op == CRB_OP_ROT_RIGHT) begin
            next_status[ST_CARRY] = i_exec.a[0]; // RULE10
        end
        // Reset-cause flags only from events and the i_power_resetn input
        if (i_event.wdog_clear) begin
            next_status[ST_WDOG] = 1'b1; // RULE3 RULE4
            next_status[ST_SLEEP] = 1'b1; // RULE5
        end
        if (i_event.sleep_enter) begin
            next_status[ST_WDOG] = 1'b1; // RULE4
            next_status[ST_SLEEP] = 1'b0; // RULE5
        end
        if (i_event.wdog_timeout) begin
            next_status[ST_WDOG] = 1'b0; // RULE4
        end
        if (i_event.power_reset || !i_power_resetn) begin
            next_status = RST_STATUS; // RULE12
        end
        next_status = next_status & MASK_STATUS; // RULE11
    end

    // ------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------
    always_comb begin
        next_rd_data = RST_ZERO_BYTE; // RULE14 RULE20
        if (i_rd) begin
            if (rd_eff[6:0] <= OFF_CORE_LAST) begin
                unique case (rd_eff[6:0]) // RULE22
                    OFF_PROGRAM_COUNTER_LOW: next_rd_data = pc_low;
                    OFF_ALU_AND_RESET_FLAGS: next_rd_data = status; // RULE11
                    OFF_POINTER0_LOW: next_rd_data = ptr0_low;
                    OFF_POINTER0_HIGH: next_rd_data = ptr0_high;
                    OFF_POINTER1_LOW: next_rd_data = ptr1_low;
                    OFF_POINTER1_HIGH: next_rd_data = ptr1_high;
                    OFF_BANK_SELECT: next_rd_data = bank_select;
                    OFF_WORKING_ACCUMULATOR: next_rd_data = wacc;
                    OFF_PC_HIGH_LATCH: next_rd_data = program_counter_high_latch;
                    OFF_INTERRUPT_GLOBAL_CONTROL: next_rd_data = intctl;
                    default: next_rd_data = RST_ZERO_BYTE;
                endcase
            end else if (rd_eff[6:0] >= OFF_COMMON_FIRST) begin
                next_rd_data = common[rd_eff[3:0]]; // RULE16
            end else if (rd_eff[6:0] >= OFF_GPR_FIRST
                && rd_eff[6:0] <= OFF_GPR_LAST) begin
                next_rd_data = general_purpose_ram[32'(rd_eff[11:7]) * GPR_BYTES
                    + 32'(rd_eff[6:0] - OFF_GPR_FIRST)]; // RULE15
            end
            // Special function region is outside this block: reads zero
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            pc_low <= RST_ZERO_BYTE; // RULE18
            ptr0_low <= RST_ZERO_BYTE;
            ptr0_high <= RST_ZERO_BYTE;
            ptr1_low <= RST_ZERO_BYTE;
            ptr1_high <= RST_ZERO_BYTE;
            bank_select <= RST_ZERO_BYTE;
            wacc <= RST_ZERO_BYTE;
            program_counter_high_latch <= RST_ZERO_BYTE;
            intctl <= RST_INTERRUPT_GLOBAL_CONTROL;
            rd_data <= RST_ZERO_BYTE;
        end else begin
            pc_low <= next_pc_low;
            ptr0_low <= next_ptr0_low;
            ptr0_high <= next_ptr0_high;
            ptr1_low <= next_ptr1_low;
            ptr1_high <= next_ptr1_high;
            bank_select <= next_bank_select;
            wacc <= next_wacc;
            program_counter_high_latch <= next_program_counter_high_latch;
            intctl <= next_intctl;
            rd_data <= next_rd_data;
        end
    end

    // No async reset: resets other than power must keep the ALU flags
    always_ff @(posedge i_clk) begin
        status <= next_status; // RULE12
    end
    // RAM carries no reset; contents are unknown at power-up
    always_ff @(posedge i_clk) begin
        if (wr_en && (!wr_core || wr_off == OFF_INDIRECT_PORT0
            || wr_off == OFF_INDIRECT_PORT1)) begin
            if (wr_addr[6:0] >= OFF_COMMON_FIRST) begin
                common[wr_addr[3:0]] <= result; // RULE16
            end else if (wr_addr[6:0] >= OFF_GPR_FIRST
                && wr_addr[6:0] <= OFF_GPR_LAST) begin
                general_purpose_ram[32'(wr_addr[11:7]) * GPR_BYTES
                    + 32'(wr_addr[6:0] - OFF_GPR_FIRST)] <= result; // RULE15
            end
            // RULE14: 0x0C-0x1F left to peripherals, none stored here
        end
    end

    assign o_rd_data = rd_data;
    assign o_status = status;
    assign o_pc_high_latch = program_counter_high_latch;
    assign o_working_accumulator = wacc;
    assign o_pointer0 = {ptr0_high, ptr0_low}; // RULE21
    assign o_pointer1 = {ptr1_high, ptr1_low}; // RULE21

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    upper_zero_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        status[7:5] == 3'b000) else $error("status upper bits set"); // RULE11
    add_carry_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        i_exec.valid && i_exec.op == CRB_OP_ADD && i_power_resetn
        && !i_event.power_reset |=> status[ST_CARRY]
        == $past(sum[8])) else $error("add carry wrong"); // RULE8
    zero_flag_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        flagop && i_power_resetn && !i_event.power_reset
        |=> status[ST_ZERO] == $past(zres)) else $error("zero wrong"); // RULE6
    sleep_flag_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        i_event.sleep_enter && i_power_resetn && !i_event.power_reset
        |=> !status[ST_SLEEP]) else $error("sleep flag set"); // RULE5
    timeout_flag_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        i_event.wdog_timeout && i_power_resetn && !i_event.power_reset
        |=> !status[ST_WDOG]) else $error("timeout flag set"); // RULE4
    protect_flags_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        i_event == 4'b0000 && i_power_resetn
        |=> status[4:3] == $past(status[4:3]))
        else $error("protected flag moved"); // RULE3
    latch_width_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        !program_counter_high_latch[7]) else $error("latch bit7 set"); // RULE17
    power_reset_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        !i_power_resetn |=> status == RST_STATUS)
        else $error("power reset status"); // RULE12
    sub_cover_c: cover property (@(posedge i_clk)
        i_exec.valid && i_exec.op == CRB_OP_SUB);
    rot_cover_c: cover property (@(posedge i_clk)
        i_exec.valid && i_exec.op == CRB_OP_ROT_LEFT);
    sleep_cover_c: cover property (@(posedge i_clk) i_event.sleep_enter);
endmodule : crb_core_regs

// ### crb_pkg.sv
package crb_pkg;
    // ------------------------------------------------------------------
    // Core register offsets within a bank
    // ------------------------------------------------------------------
    localparam logic [6:0] OFF_INDIRECT_PORT0 = 7'h00;
    localparam logic [6:0] OFF_INDIRECT_PORT1 = 7'h01;
    localparam logic [6:0] OFF_PROGRAM_COUNTER_LOW = 7'h02;
    localparam logic [6:0] OFF_ALU_AND_RESET_FLAGS = 7'h03;
    localparam logic [6:0] OFF_POINTER0_LOW = 7'h04;
    localparam logic [6:0] OFF_POINTER0_HIGH = 7'h05;
    localparam logic [6:0] OFF_POINTER1_LOW = 7'h06;
    localparam logic [6:0] OFF_POINTER1_HIGH = 7'h07;
    localparam logic [6:0] OFF_BANK_SELECT = 7'h08;
    localparam logic [6:0] OFF_WORKING_ACCUMULATOR = 7'h09;
    localparam logic [6:0] OFF_PC_HIGH_LATCH = 7'h0a;
    localparam logic [6:0] OFF_INTERRUPT_GLOBAL_CONTROL = 7'h0b;
    localparam logic [6:0] OFF_CORE_LAST = 7'h0b;
    localparam logic [6:0] OFF_SFR_LAST = 7'h1f;
    localparam logic [6:0] OFF_GPR_FIRST = 7'h20;
    localparam logic [6:0] OFF_GPR_LAST = 7'h6f;
    localparam logic [6:0] OFF_COMMON_FIRST = 7'h70;
    localparam logic [4:0] BANK_PPS_FIRST = 5'h1b;
    localparam logic [4:0] BANK_PPS_LAST = 5'h1d;
    localparam int GPR_BYTES = 80;
    localparam int COMMON_BYTES = 16;
    localparam int BANKS = 32;

    // ------------------------------------------------------------------
    // Status field positions and reset values
    // ------------------------------------------------------------------
    localparam int ST_CARRY = 0;
    localparam int ST_NIBBLE = 1;
    localparam int ST_ZERO = 2;
    localparam int ST_SLEEP = 3;
    localparam int ST_WDOG = 4;
    localparam int NIBBLE_BIT = 4;
    localparam logic [7:0] RST_STATUS = 8'h18;
    localparam logic [7:0] RST_INTERRUPT_GLOBAL_CONTROL = 8'h01;
    localparam logic [7:0] RST_ZERO_BYTE = 8'h00;
    localparam logic [7:0] MASK_BANK_SELECT = 8'h1f;
    localparam logic [7:0] MASK_PC_HIGH_LATCH = 8'h7f;
    localparam logic [7:0] MASK_INTERRUPT_GLOBAL_CONTROL = 8'hc1;
    localparam logic [7:0] MASK_STATUS = 8'h1f;

    typedef enum logic [2:0] {
        CRB_OP_NONE = 3'b000,
        CRB_OP_ADD = 3'b001,
        CRB_OP_SUB = 3'b010,
        CRB_OP_LOGIC = 3'b011,
        CRB_OP_ROT_LEFT = 3'b100,
        CRB_OP_ROT_RIGHT = 3'b101,
        CRB_OP_ZEROING = 3'b110,
        CRB_OP_MOVE = 3'b111
    } crb_op_type;

    typedef struct packed {
        logic wdog_clear;
        logic sleep_enter;
        logic wdog_timeout;
        logic power_reset;
    } crb_event_type;

    typedef struct packed {
        logic valid;
        crb_op_type op;
        logic [7:0] a;
        logic [7:0] b;
        logic dest_write;
        logic [6:0] dest_off;
    } crb_exec_type;
endpackage : crb_pkg

// ### crb_cpu_model.sv
`timescale 1ns/1ps
module crb_cpu_model
    import crb_pkg::*;
(
    input wire logic i_clk,
    output crb_exec_type o_exec
);
    initial begin
        o_exec = '0;
    end

    // One instruction per call; valid is high for one rising edge, then low for at least one cycle
    task automatic issue(input crb_op_type op, input logic [7:0] a,
            input logic [7:0] b, input logic [6:0] dest);
        @(negedge i_clk);
        o_exec <= '{valid: 1'b1, op: op, a: a, b: b, dest_write: 1'b1,
                dest_off: dest};
        @(negedge i_clk);
        o_exec.valid <= 1'b0;
    endtask : issue
endmodule : crb_cpu_model

// ### core_register_bank_and_status_tb.sv
`timescale 1ns/1ps
module core_register_bank_and_status_tb
    import crb_pkg::*;
;
    logic i_clk, i_resetn, i_power_resetn, i_pc_load, i_rd, i_indirect_sel;
    logic [7:0] i_pc_low, o_rd_data, o_status, o_pc_high_latch, o_wacc, d;
    logic [11:0] i_rd_addr;
    logic [15:0] o_pointer0, o_pointer1;
    crb_exec_type i_exec;
    crb_event_type i_event;
    int n_mismatch = 0;
    int checks_done = 0;
    logic [31:0] seed = 32'hdd84;
    logic [10:0] e;
    logic [7:0] m;
    logic [1:0] cf;
    crb_op_type op;
    crb_op_type ops [5] = '{CRB_OP_ADD, CRB_OP_SUB, CRB_OP_LOGIC,
            CRB_OP_ROT_LEFT, CRB_OP_ROT_RIGHT};

    crb_cpu_model i_cpu (.i_clk(i_clk), .o_exec(i_exec));
    crb_core_regs i_dut (.i_clk(i_clk), .i_resetn(i_resetn),
        .i_power_resetn(i_power_resetn), .i_exec(i_exec), .i_event(i_event),
        .i_pc_load(i_pc_load), .i_pc_low(i_pc_low), .i_rd(i_rd),
        .i_rd_addr(i_rd_addr), .i_indirect_sel(i_indirect_sel),
        .o_rd_data(o_rd_data),
        .o_status(o_status), .o_pc_high_latch(o_pc_high_latch),
        .o_working_accumulator(o_wacc), .o_pointer0(o_pointer0),
        .o_pointer1(o_pointer1));

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr

    // Returns {nibble, carry, zero, result}; cf is {nibble, carry} before
    function automatic logic [10:0] alu(input crb_op_type op,
            input logic [7:0] a, input logic [7:0] b, input logic [1:0] cf);
        logic sub;
        logic [7:0] bb;
        logic [8:0] s;
        logic [4:0] n;
        logic [7:0] r;
        logic [1:0] f;
        sub = (op == CRB_OP_SUB);
        // Subtract is add of the two's complement, carries are no-borrow
        bb = sub ? ~b : b;
        s = {1'b0, a} + {1'b0, bb} + {8'h00, sub};
        n = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, sub};
        r = s[7:0];
        f = {n[4], s[8]};
        case (op)
            CRB_OP_LOGIC: begin
                r = a;
                f = cf;
            end
            CRB_OP_ROT_LEFT: begin
                r = {a[6:0], cf[0]};
                f = {cf[1], a[7]};
            end
            CRB_OP_ROT_RIGHT: begin
                r = {cf[0], a[7:1]};
                f = {cf[1], a[0]};
            end
            default: ;
        endcase
        return {f, r == 8'h00, r};
    endfunction : alu

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic rd(input logic [11:0] addr, output logic [7:0] q);
        @(negedge i_clk);
        i_rd = 1'b1;
        i_rd_addr = addr;
        @(negedge i_clk);
        i_rd = 1'b0;
        q = o_rd_data;
    endtask : rd

    task automatic ev(input crb_event_type v, input logic [7:0] exp);
        @(negedge i_clk);
        i_event = v;
        @(negedge i_clk);
        i_event = '0;
        chk(o_status, exp);
    endtask : ev

    task automatic pulse_reset;
        @(negedge i_clk);
        i_resetn = 1'b0;
        @(negedge i_clk);
        i_resetn = 1'b1;
    endtask : pulse_reset

    task automatic close_out;
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : close_out

    // ------------------------------------------------------------------
    // Clock, guard and main sequence
    // ------------------------------------------------------------------
    initial begin
        i_clk = 1'b0;
        forever #10 i_clk = ~i_clk;
    end

    initial begin
        #1000000;
        n_mismatch++;
        close_out();
    end

    initial begin
        {i_resetn, i_power_resetn, i_pc_load, i_rd} = 4'h0;
        i_indirect_sel = 1'b0;
        i_pc_low = 8'h00;
        i_rd_addr = 12'h000;
        i_event = '0;
        repeat (8) @(negedge i_clk);
        // Power-up is a power reset
        i_resetn = 1'b1;
        i_power_resetn = 1'b1;
        chk(o_status, 8'h18);
        chk(o_pointer0, 16'h0000);
        rd(12'h00b, d);
        chk(d, 8'h01);
        cf = 2'b00;
        for (int k = 0; k < 80; k++) begin
            seed = lfsr(seed);
            op = ops[seed[2:0] % 5];
            i_cpu.issue(op, seed[15:8], seed[23:16], OFF_WORKING_ACCUMULATOR);
            e = alu(op, seed[15:8], seed[23:16], cf);
            cf = e[10:9];
            m = (op == CRB_OP_LOGIC) ? 8'h04 : 8'h07;
            m = (op inside {CRB_OP_ROT_LEFT, CRB_OP_ROT_RIGHT}) ? 8'h01 : m;
            chk(o_wacc, e[7:0]);
            chk(o_status & m, {5'h00, e[8], e[10:9]} & m);
        end
        i_cpu.issue(CRB_OP_SUB, 8'h35, 8'h35, OFF_WORKING_ACCUMULATOR);
        chk(o_status, 8'h1f);
        // Status as a destination: protected and unimplemented bits hold
        i_cpu.issue(CRB_OP_MOVE, 8'he3, 8'h00, OFF_ALU_AND_RESET_FLAGS);
        chk(o_status, 8'h1b);
        i_cpu.issue(CRB_OP_ZEROING, 8'h00, 8'h00, OFF_ALU_AND_RESET_FLAGS);
        chk(o_status, 8'h1f);
        i_cpu.issue(CRB_OP_ADD, 8'h01, 8'h01, OFF_ALU_AND_RESET_FLAGS);
        chk(o_status, 8'h18);
        ev(4'b0100, 8'h10);
        i_cpu.issue(CRB_OP_MOVE, 8'hff, 8'h00, OFF_ALU_AND_RESET_FLAGS);
        chk(o_status, 8'h17);
        ev(4'b0010, 8'h07);
        ev(4'b1000, 8'h1f);
        ev(4'b0001, 8'h18);
        i_cpu.issue(CRB_OP_MOVE, 8'h07, 8'h00, OFF_ALU_AND_RESET_FLAGS);
        @(negedge i_clk);
        i_power_resetn = 1'b0;
        @(negedge i_clk);
        i_power_resetn = 1'b1;
        chk(o_status, 8'h18);
        i_cpu.issue(CRB_OP_ROT_LEFT, 8'h80, 8'h00, OFF_ALU_AND_RESET_FLAGS);
        chk(o_status, 8'h19);
        // Banking, mirrors and indirect ports
        i_cpu.issue(CRB_OP_MOVE, 8'h05, 8'h00, OFF_BANK_SELECT);
        // Offset 0x09 reaches the core registers in bank 5 as in every bank
        i_cpu.issue(CRB_OP_MOVE, 8'h3c, 8'h00, OFF_WORKING_ACCUMULATOR);
        chk(o_wacc, 8'h3c);
        i_cpu.issue(CRB_OP_MOVE, 8'h25, 8'h00, OFF_POINTER0_LOW);
        i_cpu.issue(CRB_OP_MOVE, 8'h02, 8'h00, OFF_POINTER0_HIGH);
        chk(o_pointer0, 16'h0225);
        i_cpu.issue(CRB_OP_MOVE, 8'h5a, 8'h00, OFF_INDIRECT_PORT0);
        rd(12'h125, d);
        chk(d, 8'h5a);
        i_cpu.issue(CRB_OP_MOVE, 8'h25, 8'h00, OFF_POINTER1_LOW);
        i_cpu.issue(CRB_OP_MOVE, 8'h02, 8'h00, OFF_POINTER1_HIGH);
        rd(12'h001, d);
        chk(d, 8'h5a);
        i_indirect_sel = 1'b1;
        rd(12'h3ff, d);
        i_indirect_sel = 1'b0;
        chk(d, 8'h5a);
        rd(12'h384, d);
        chk(d, 8'h25);
        i_cpu.issue(CRB_OP_MOVE, 8'h77, 8'h00, OFF_COMMON_FIRST);
        rd(12'h4f0, d);
        chk(d, 8'h77);
        i_cpu.issue(CRB_OP_MOVE, 8'h99, 8'h00, 7'h10);
        rd(12'h290, d);
        chk(d, 8'h00);
        rd(12'he10, d);
        chk(d, 8'h00);
        i_cpu.issue(CRB_OP_MOVE, 8'hff, 8'h00, OFF_PC_HIGH_LATCH);
        chk(o_pc_high_latch, 8'h7f);
        @(negedge i_clk);
        i_pc_load = 1'b1;
        i_pc_low = 8'ha5;
        @(negedge i_clk);
        i_pc_load = 1'b0;
        rd(12'h002, d);
        chk(d, 8'ha5);
        i_cpu.issue(CRB_OP_MOVE, 8'h05, 8'h00, OFF_ALU_AND_RESET_FLAGS);
        pulse_reset();
        chk(o_status, 8'h1d);
        rd(12'h082, d);
        chk(d, 8'h00);
        close_out();
    end
endmodule : core_register_bank_and_status_tb
